// *** hdl/dfs_pkg.sv ***
// constants, register map and carrier types of the drive fault supervisor
package dfs_pkg;
   // ****************************************
   // register map, AXI4-Lite byte addresses
   // ****************************************
   localparam logic [3:0] OFS_CFG = 4'h0;
   localparam logic [3:0] OFS_DIN_SEL = 4'h4;
   localparam logic [3:0] OFS_CLEAR = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;
   // cfg fields
   localparam int CFG_LIMIT_LSB = 0;
   localparam int CFG_DELAY_LSB = 8;
   localparam int CFG_STOPSEL_LSB = 24;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [15:0] DIN_SEL_RESET = 16'h0000;
   // status fields
   localparam int ST_CODE_LSB = 0;
   localparam int ST_FAULT_BIT = 8;
   localparam int ST_CLASS_BIT = 9;
   localparam int ST_ACK_BIT = 10;
   localparam int ST_RUN_BIT = 11;
   localparam int ST_TRIES_LSB = 12;
   // ****************************************
   // setting values
   // ****************************************
   localparam logic [3:0] STOPSEL_CLR_MAX = 4'h3;
   localparam logic [3:0] DIN_FN_CLEAR = 4'h7;
   localparam logic [7:0] CLR_REQ_A = 8'h01;
   localparam logic [7:0] CLR_REQ_B = 8'h02;
   // ****************************************
   // fault codes
   // ****************************************
   localparam logic [7:0] F_NONE = 8'h00;
   localparam logic [7:0] F_AUX = 8'h02;
   localparam logic [7:0] F_RIPPLE = 8'h03;
   localparam logic [7:0] F_UNDER_V = 8'h04;
   localparam logic [7:0] F_OVER_V = 8'h05;
   localparam logic [7:0] F_STALL = 8'h06;
   localparam logic [7:0] F_HS_HOT = 8'h08;
   localparam logic [7:0] F_TRIES = 8'h21;
   // ****************************************
   // timing
   // ****************************************
   localparam longint CLK_PERIOD_NS = 8;
   localparam longint DELAY_UNIT_NS = 100_000_000;
   localparam int DELAY_UNIT_CYC = int'(DELAY_UNIT_NS / CLK_PERIOD_NS);
   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic aux_open;   // interlock open
      logic ripple;     // excessive bus ripple
      logic under_v;    // bus below minimum
      logic over_v;     // bus above maximum
      logic stall;      // cannot accelerate
      logic hs_hot;     // heatsink_over_temperature
   } dfs_flt_t;
   typedef struct packed {
      logic [7:0] code;   // latest fault code
      logic flash_code;   // flash fault number
      logic flash_ind;    // flash fault indicator
      logic [1:0] state;  // 0 ready 1 run 2 fault
      logic changed;      // one-cycle state change pulse
   } dfs_kp_t;
   typedef enum logic [1:0] {KP_READY, KP_RUN, KP_FAULT} dfs_kpst_t;
endpackage : dfs_pkg

// *** hdl/dfs_top.sv ***
// drive fault supervisor with AXI4-Lite register slave
`timescale 1ns/100ps
module dfs_top #(
   parameter int UNIT_CYC = dfs_pkg::DELAY_UNIT_CYC, // cycles per delay unit
   parameter int NDIN = 4                            // digital inputs
) (
   input wire logic clk_sys,                  // 125 MHz
   input wire logic arst_n,                   // async reset, active low
   input wire dfs_pkg::dfs_flt_t flt_pins,    // fault detector flags
   input wire logic esc_key,                  // escape key pin
   input wire logic stop_key,                 // stop key pin
   input wire logic start_key,                // start command pin
   input wire logic [NDIN-1:0] din,           // digital input pins
   output dfs_pkg::dfs_kp_t kp,               // keypad indication
   output logic drive_run,                    // drive output enable
   output logic fault_active,                 // faulted state
   input wire logic [3:0] s_axi_awaddr,       // write address
   input wire logic s_axi_awvalid,            // write address valid
   output logic s_axi_awready,                // write address ready
   input wire logic [31:0] s_axi_wdata,       // write data
   input wire logic [3:0] s_axi_wstrb,        // write strobes
   input wire logic s_axi_wvalid,             // write data valid
   output logic s_axi_wready,                 // write data ready
   output logic [1:0] s_axi_bresp,            // write response
   output logic s_axi_bvalid,                 // write response valid
   input wire logic s_axi_bready,             // write response ready
   input wire logic [3:0] s_axi_araddr,       // read address
   input wire logic s_axi_arvalid,            // read address valid
   output logic s_axi_arready,                // read address ready
   output logic [31:0] s_axi_rdata,           // read data
   output logic [1:0] s_axi_rresp,            // read response
   output logic s_axi_rvalid,                 // read data valid
   input wire logic s_axi_rready              // read data ready
);
   import dfs_pkg::*;
   typedef enum logic [1:0] {S_READY, S_RUN, S_FAULT} dfs_st_t;
   localparam int NPIN = 9 + NDIN;

   // ****************************************
   // reset release and pin synchronisers
   // ****************************************
   logic [1:0] rst_q;
   logic rst_n;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) rst_q <= 2'b00;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   logic [NPIN-1:0] pin_meta_q, pin_q, pin_last_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= '0;
         pin_q <= '0;
         pin_last_q <= '0;
      end else begin
         pin_meta_q <= {din, start_key, stop_key, esc_key, flt_pins};
         pin_q <= pin_meta_q;
         pin_last_q <= pin_q;
      end
   end
   dfs_flt_t flt;
   logic esc_p, stop_p, start_p;
   logic [NDIN-1:0] din_tgl;
   assign flt = dfs_flt_t'(pin_q[5:0]);
   assign esc_p = pin_q[6] & ~pin_last_q[6];
   assign stop_p = pin_q[7] & ~pin_last_q[7];
   assign start_p = pin_q[8] & ~pin_last_q[8];
   assign din_tgl = pin_q[NPIN-1:9] ^ pin_last_q[NPIN-1:9];

   // ****************************************
   // register slave
   // ****************************************
   logic [31:0] cfg_q;
   logic [4*NDIN-1:0] dsel_q;
   logic clr_wr_q;
   logic wr_go, wr_cfg, wr_dsel, wr_clr, rd_go;
   logic [7:0] lim;
   logic [15:0] dly_set;
   logic [3:0] stop_sel;
   assign lim = cfg_q[CFG_LIMIT_LSB +: 8];
   assign dly_set = cfg_q[CFG_DELAY_LSB +: 16];
   assign stop_sel = cfg_q[CFG_STOPSEL_LSB +: 4];
   // both channels taken together, one write outstanding at most
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
   assign wr_cfg = wr_go & (s_axi_awaddr == OFS_CFG);
   assign wr_dsel = wr_go & (s_axi_awaddr == OFS_DIN_SEL);
   assign wr_clr = wr_go & (s_axi_awaddr == OFS_CLEAR) & s_axi_wstrb[0];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RESET;
         dsel_q <= DIN_SEL_RESET[4*NDIN-1:0];
         clr_wr_q <= 1'b0;
      end else begin
         for (int b = 0; b < 4; b++)
            if (wr_cfg && s_axi_wstrb[b]) cfg_q[8*b +: 8] <= s_axi_wdata[8*b +: 8];
         for (int b = 0; b < NDIN / 2; b++)
            if (wr_dsel && s_axi_wstrb[b]) dsel_q[8*b +: 8] <= s_axi_wdata[8*b +: 8];
         // request acts once, reads back as zero
         clr_wr_q <= wr_clr & ((s_axi_wdata[7:0] == CLR_REQ_A) |
                               (s_axi_wdata[7:0] == CLR_REQ_B));
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (s_axi_awaddr[3:2] == OFS_STATUS[3:2]) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic [31:0] status;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         unique case (s_axi_araddr[3:2])
            OFS_CFG[3:2]: s_axi_rdata <= cfg_q;
            OFS_DIN_SEL[3:2]: s_axi_rdata <= 32'(dsel_q);
            OFS_CLEAR[3:2]: s_axi_rdata <= 32'h0000_0000;
            OFS_STATUS[3:2]: s_axi_rdata <= status;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // fault detection and classification
   // ****************************************
   logic det;
   logic [7:0] det_code;
   logic det_cls2;
   always_comb begin
      det = 1'b1;
      det_cls2 = 1'b0;
      if (flt.aux_open) det_code = F_AUX;
      else if (flt.ripple) begin
         det_code = F_RIPPLE;
         det_cls2 = 1'b1;
      end
      else if (flt.under_v) det_code = F_UNDER_V;
      else if (flt.over_v) det_code = F_OVER_V;
      else if (flt.stall) det_code = F_STALL;
      else if (flt.hs_hot) det_code = F_HS_HOT;
      else begin
         det = 1'b0;
         det_code = F_NONE;
      end
   end

   dfs_st_t st_q;
   logic [7:0] code_q;
   logic cls2_q, ack_q;
   logic cause;
   // cause of the held fault still present; F33 has none of its own
   always_comb begin
      unique case (code_q)
         F_AUX: cause = flt.aux_open;
         F_RIPPLE: cause = flt.ripple;
         F_UNDER_V: cause = flt.under_v;
         F_OVER_V: cause = flt.over_v;
         F_STALL: cause = flt.stall;
         F_HS_HOT: cause = flt.hs_hot;
         default: cause = 1'b0;
      endcase
   end

   // ****************************************
   // clear paths and auto restart timing
   // ****************************************
   logic din_clr, req_clr, man_clr;
   always_comb begin
      din_clr = 1'b0;
      for (int i = 0; i < NDIN; i++)
         if (din_tgl[i] && dsel_q[4*i +: 4] == DIN_FN_CLEAR) din_clr = 1'b1;
   end
   assign req_clr = (stop_p & (stop_sel <= STOPSEL_CLR_MAX))
                    | clr_wr_q | din_clr;
   assign man_clr = st_q == S_FAULT & req_clr & ~cause;

   logic tmr_on_q;
   logic [15:0] dly_q;
   logic [31:0] pre_q;
   logic [7:0] tries_q;
   logic fire, quiet_clr;
   assign fire = st_q == S_FAULT & tmr_on_q & dly_q == 16'h0000;
   // zero delay gives a reset without a new start for supply/heat faults
   assign quiet_clr = dly_set == 16'h0000 &
      (code_q == F_UNDER_V | code_q == F_OVER_V | code_q == F_HS_HOT);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tmr_on_q <= 1'b0;
         dly_q <= 16'h0000;
         pre_q <= 32'h0000_0000;
      end else if (st_q != S_FAULT) begin
         tmr_on_q <= det & ~det_cls2 & (lim != 8'h00);
         dly_q <= dly_set;
         pre_q <= 32'(UNIT_CYC - 1);
      end else if (fire) begin
         // failed try with tries left rearms the timer
         tmr_on_q <= cause & (tries_q > 8'h01);
         dly_q <= dly_set;
         pre_q <= 32'(UNIT_CYC - 1);
      end else if (tmr_on_q) begin
         if (pre_q == 32'h0000_0000) begin
            pre_q <= 32'(UNIT_CYC - 1);
            dly_q <= dly_q - 16'h0001;
         end else begin
            pre_q <= pre_q - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) tries_q <= 8'h00;
      else if (st_q != S_FAULT) tries_q <= lim;
      else if (fire) tries_q <= tries_q - 8'h01;
   end

   // ****************************************
   // drive state
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_READY;
         code_q <= F_NONE;
         cls2_q <= 1'b0;
      end else begin
         unique case (st_q)
            S_READY, S_RUN: begin
               if (det) begin
                  st_q <= S_FAULT;
                  code_q <= det_code;
                  cls2_q <= det_cls2;
               end else if (st_q == S_READY && start_p) st_q <= S_RUN;
               else if (st_q == S_RUN && stop_p) st_q <= S_READY;
            end
            S_FAULT: begin
               // start commands have no path out of here
               if (man_clr) st_q <= S_READY;
               else if (fire && !cls2_q) begin
                  if (!cause) st_q <= quiet_clr ? S_READY : S_RUN;
                  else if (tries_q <= 8'h01) begin
                     code_q <= F_TRIES;
                     cls2_q <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) ack_q <= 1'b0;
      else if (st_q != S_FAULT || (fire && cause && tries_q <= 8'h01)) ack_q <= 1'b0;
      else if (esc_p) ack_q <= 1'b1;
   end

   // ****************************************
   // keypad and outputs
   // ****************************************
   logic [1:0] st_last_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) st_last_q <= 2'(KP_READY);
      else st_last_q <= kp.state;
   end
   always_comb begin
      kp.code = code_q;
      kp.flash_code = st_q == S_FAULT & ~ack_q;
      kp.flash_ind = st_q == S_FAULT & ~ack_q;
      unique case (st_q)
         S_READY: kp.state = 2'(KP_READY);
         S_RUN: kp.state = 2'(KP_RUN);
         S_FAULT: kp.state = 2'(KP_FAULT);
      endcase
      kp.changed = kp.state != st_last_q;
   end
   assign drive_run = st_q == S_RUN;
   assign fault_active = st_q == S_FAULT;
   always_comb begin
      status = 32'h0000_0000;
      status[ST_CODE_LSB +: 8] = code_q;
      status[ST_FAULT_BIT] = fault_active;
      status[ST_CLASS_BIT] = cls2_q;
      status[ST_ACK_BIT] = ack_q;
      status[ST_RUN_BIT] = drive_run;
      status[ST_TRIES_LSB +: 8] = tries_q;
   end

   // ****************************************
   // assertions
   // ****************************************
   sequence s_new_fault;
      st_q != S_FAULT && det;
   endsequence
   sequence s_clear_ok;
      st_q == S_FAULT && req_clr && !cause;
   endsequence
   sequence s_auto_ok;
      fire && !cause && !cls2_q && !man_clr;
   endsequence

   a_fault_stops_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_new_fault |=> st_q == S_FAULT && !drive_run && code_q == $past(det_code))
      else $error("fault did not stop the drive");
   a_timer_loaded: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_new_fault ##0 (!det_cls2 && lim != 8'h00)
      |=> tmr_on_q && dly_q == $past(dly_set))
      else $error("restart delay timer not loaded");
   a_no_auto_type2: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q == S_FAULT && cls2_q && !man_clr |=> st_q == S_FAULT)
      else $error("type 2 fault left without manual clear");
   a_esc_keeps_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q == S_FAULT && esc_p && !req_clr && !fire
      |=> ack_q && st_q == S_FAULT && !kp.flash_code)
      else $error("escape did not acknowledge only");
   a_manual_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_clear_ok |=> st_q == S_READY && !drive_run)
      else $error("permitted clear did not clear");
   a_stop_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q == S_FAULT && stop_p && stop_sel > STOPSEL_CLR_MAX && !clr_wr_q
      && !din_clr && !fire |=> st_q == S_FAULT)
      else $error("stop cleared a fault with stop select above 3");
   a_auto_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_auto_ok |=> drive_run == !$past(quiet_clr) && !fault_active)
      else $error("automatic reset did not restart as set");
   a_tries_spent: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fire && cause && !cls2_q && !man_clr && tries_q == 8'h01
      |=> code_q == F_TRIES && cls2_q && st_q == S_FAULT)
      else $error("spent tries did not raise F33");
   a_flash_until_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_new_fault |=> (kp.flash_ind && kp.flash_code) ##1
      (kp.flash_ind && kp.flash_code || ack_q || st_q != S_FAULT))
      else $error("unacknowledged fault not flashing");
   a_no_start_in_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q == S_FAULT && start_p && !fire |=> !drive_run)
      else $error("start accepted while faulted");
endmodule : dfs_top

// *** verification/dfs_panel.sv ***
// operator panel model: keypad keys and digital input pins
`timescale 1ns/100ps
module dfs_panel (
   input wire logic clk_sys, // system clock
   output logic esc_key,     // escape key
   output logic stop_key,    // stop key
   output logic start_key,   // start key
   output logic [3:0] din    // digital inputs
);
   // ****************************************
   // key presses and input toggles
   // ****************************************
   initial begin
      esc_key = 1'b0;
      stop_key = 1'b0;
      start_key = 1'b0;
      din = 4'h0;
   end
   // held 4 cycles, well past the 2-flop synchroniser
   task automatic press(input int k);
      @(posedge clk_sys);
      esc_key <= k == 0;
      stop_key <= k == 1;
      start_key <= k > 1;
      repeat (4) @(posedge clk_sys);
      esc_key <= 1'b0;
      stop_key <= 1'b0;
      start_key <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : press
   task automatic flip(input int i);
      @(posedge clk_sys);
      din[i] <= ~din[i];
      repeat (5) @(posedge clk_sys);
   endtask : flip
endmodule : dfs_panel

// *** verification/dfs_top_bench.sv ***
// self-checking bench of the drive fault supervisor
`timescale 1ns/100ps
module dfs_top_bench;
   import dfs_pkg::*;
   localparam int UC = 4;
   logic clk_sys, arst_n, esc_key, stop_key, start_key;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, drive_run, fault_active;
   logic [3:0] din, awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   dfs_flt_t flt;
   dfs_kp_t kp;
   logic [7:0] codes [6];
   int num_errors = 0;
   int samples_checked = 0;
   int nchg = 0;
   logic [3:0] strb = 4'hF;
   dfs_top #(.UNIT_CYC(UC), .NDIN(4)) dut (.clk_sys(clk_sys),
      .arst_n(arst_n), .flt_pins(flt), .esc_key(esc_key),
      .stop_key(stop_key), .start_key(start_key), .din(din), .kp(kp),
      .drive_run(drive_run), .fault_active(fault_active),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   dfs_panel p (.clk_sys(clk_sys), .esc_key(esc_key), .stop_key(stop_key),
      .start_key(start_key), .din(din));
   // ****************************************
   // helpers
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (kp.changed === 1'b1) nchg++;
   function automatic logic [31:0] cfg(input int lim, dly, ss);
      return {4'h0, 4'(ss), 16'(dly), 8'(lim)};
   endfunction : cfg
   task automatic fail(input string m);
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask : fail
   task automatic chk_val(input logic [31:0] got, exp, input string m);
      samples_checked++;
      if (got !== exp) fail(m);
   endtask : chk_val
   // waits a bounded span for the keypad state
   task automatic chk_st(input dfs_kpst_t exp);
      int n;
      n = 0;
      while (kp.state !== exp && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      chk_val(32'(kp.state), 32'(exp), "keypad state");
   endtask : chk_st
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk_sys); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk_sys); while (!bvalid);
      chk_val(32'(bresp), 32'(er), "write response");
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (!rvalid);
      d = rdata;
      chk_val(32'(rresp), 32'h0, "read response");
      rready <= 1'b0;
   endtask : rd
   task automatic fault_on(input int i);
      p.press(2);
      chk_st(KP_RUN);
      flt <= dfs_flt_t'(6'h01 << i);
      chk_st(KP_FAULT);
   endtask : fault_on
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail("watchdog expired");
      end_of_test();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      logic [31:0] d;
      logic [7:0] cv;
      int n0;
      arst_n = 1'b0;
      flt = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      codes = '{F_HS_HOT, F_STALL, F_OVER_V, F_UNDER_V, F_RIPPLE, F_AUX};
      void'($urandom(32'h4BDC));
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd(OFS_CFG, d);
      chk_val(d, CFG_RESET, "cfg reset");
      rd(OFS_STATUS, d);
      chk_val(d, 32'h0, "status reset");
      chk_st(KP_READY);
      wr(OFS_STATUS, 32'h1, 2'b10);
      wr(OFS_DIN_SEL, 32'h7, 2'b00);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         n0 = nchg;
         wr(OFS_CFG, cfg(0, 5, $urandom_range(3)), 2'b00);
         fault_on(i);
         chk_val(32'(kp.code), 32'(codes[i]), "code");
         chk_val({kp.flash_code, kp.flash_ind, drive_run}, 3'h6, "flash");
         p.press(2);
         chk_st(KP_FAULT);
         p.press(0);
         chk_val({kp.flash_code, kp.flash_ind, fault_active}, 3'h1, "ack");
         rd(OFS_STATUS, d);
         chk_val(d[11:0], {2'b01, 1'(i == 4), 1'b1, codes[i]}, "status");
         cv = $urandom_range(1) ? CLR_REQ_B : CLR_REQ_A;
         wr(OFS_CLEAR, {24'h0, cv}, 2'b00);
         repeat (6) @(posedge clk_sys);
         chk_st(KP_FAULT);
         flt <= '0;
         repeat (4) @(posedge clk_sys);
         case (i % 3)
            0: wr(OFS_CLEAR, {24'h0, cv}, 2'b00);
            1: p.press(1);
            default: p.flip(0);
         endcase
         chk_st(KP_READY);
         // let the change counter see the last pulse
         @(posedge clk_sys);
         chk_val(32'(nchg - n0), 32'd3, "state changes");
      end
      $display("test manual clear done");
      wr(OFS_CFG, cfg(0, 0, 4), 2'b00);
      fault_on(5);
      flt <= '0;
      p.press(1);
      chk_st(KP_FAULT);
      // clear request without its low byte lane must not act
      strb = {3'($urandom), 1'b0};
      wr(OFS_CLEAR, {24'h0, CLR_REQ_B}, 2'b00);
      repeat (3) @(posedge clk_sys);
      chk_st(KP_FAULT);
      strb = 4'hF;
      wr(OFS_CLEAR, {24'h0, CLR_REQ_B}, 2'b00);
      chk_st(KP_READY);
      $display("test stop select done");
      wr(OFS_CFG, cfg(2, 3, 0), 2'b00);
      fault_on(5);
      flt <= '0;
      repeat (6) @(posedge clk_sys);
      chk_st(KP_FAULT);
      chk_st(KP_RUN);
      chk_val(32'(drive_run), 32'h1, "self start");
      p.press(1);
      chk_st(KP_READY);
      $display("test auto restart done");
      for (int i = 0; i < 4; i++) begin
         if (i != 1) begin
            wr(OFS_CFG, cfg(3, 0, 0), 2'b00);
            p.press(2);
            chk_st(KP_RUN);
            // short dip: with zero delay tries follow each clock
            flt <= dfs_flt_t'(6'h01 << i);
            @(posedge clk_sys);
            flt <= '0;
            chk_st(KP_FAULT);
            chk_st(KP_READY);
            chk_val(32'(kp.code), 32'(codes[i]), "zero delay code");
            chk_val(32'(drive_run), 32'h0, "no restart");
         end
      end
      $display("test zero delay done");
      wr(OFS_CFG, cfg(1, 1, 0), 2'b00);
      fault_on(1);
      repeat (30) @(posedge clk_sys);
      rd(OFS_STATUS, d);
      chk_val(d[19:0], {8'h00, 4'h3, F_TRIES}, "tries used");
      flt <= '0;
      repeat (30) @(posedge clk_sys);
      chk_st(KP_FAULT);
      p.flip(0);
      chk_st(KP_READY);
      $display("test tries exhausted done");
      end_of_test();
   end
endmodule : dfs_top_bench
